// ===== core/dmc_pkg.sv
package dmc_pkg;
  // Register byte offsets on the APB slave
  localparam logic [7:0]  OFS_MODE      = 8'h00;
  localparam logic [7:0]  OFS_EQW       = 8'h04;
  localparam logic [7:0]  OFS_SPW       = 8'h08;
  localparam logic [7:0]  OFS_SYNC      = 8'h0C;
  localparam logic [7:0]  OFS_HALF      = 8'h10;
  localparam logic [7:0]  OFS_STAT      = 8'h14;
  // Display mode register field positions
  localparam int          BIT_VIDEO_SWITCH_PIN_DISABLE      = 12;
  localparam int          BIT_PRI_HI    = 11;
  localparam int          BIT_VIDEO_WINDOW_FORMAT_SELECT      = 10;
  localparam int          BIT_FOREGROUND_HALF_OFFSET      = 9;
  localparam int          BIT_FIELD_POLARITY_SELECT      = 8;
  localparam int          BIT_CSY_HI    = 7;
  localparam int          BIT_CSY_LO    = 6;
  localparam int          BIT_PRI_LO    = 5;
  localparam logic [15:0] MODE_WMASK    = 16'h1FE0;
  localparam logic [15:0] MODE_CSY_MASK = 16'h00C0;
  localparam logic [15:0] MODE_RESET    = 16'h0000;
  // Composite sync codes and sync source modes
  localparam logic [1:0]  CS_XOR        = 2'h0;
  localparam logic [1:0]  CS_THREE      = 2'h2;
  localparam logic [1:0]  CS_HALF       = 2'h3;
  localparam logic [1:0]  SM_MASTER     = 2'h0;
  localparam logic [1:0]  SM_TV         = 2'h2;
  localparam logic [1:0]  SYNC_RESET    = 2'h2;
  // Pulse train lengths in half rasters
  localparam logic [3:0]  HALVES_THREE  = 4'h6;
  localparam logic [3:0]  HALVES_HALF   = 4'h5;
  // Half raster length default: time and derived cycles
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          HALF_RASTER_NS = 32000;
  localparam logic [15:0] HALF_RESET    = 16'(HALF_RASTER_NS / CLK_PERIOD_NS);
  // Layer identifiers and stacking orders, top layer in the low bits
  localparam logic [2:0]  LYR_CUR1      = 3'h0;
  localparam logic [2:0]  LYR_CUR2      = 3'h1;
  localparam logic [2:0]  LYR_FG        = 3'h2;
  localparam logic [2:0]  LYR_VIDEO     = 3'h3;
  localparam logic [2:0]  LYR_BG        = 3'h4;
  localparam logic [2:0]  LYR_NONE      = 3'h7;
  localparam logic [14:0] PRIO_ORDER_00 = {LYR_BG, LYR_VIDEO, LYR_FG, LYR_CUR2, LYR_CUR1};
  localparam logic [14:0] PRIO_ORDER_10 = {LYR_BG, LYR_CUR2, LYR_VIDEO, LYR_FG, LYR_CUR1};
  localparam logic [14:0] PRIO_ORDER_11 = {LYR_BG, LYR_CUR2, LYR_CUR1, LYR_VIDEO, LYR_FG};
  localparam logic [10:0] FG_START_HALF = 11'h200;
  localparam logic [10:0] FG_START_ZERO = 11'h000;
endpackage

// ===== core/dmc_cfg_if.sv
`timescale 1ns/1ps
interface dmc_cfg_if;
  logic [1:0]  csync_mode;
  logic [1:0]  sync_mode;
  logic [1:0]  prio;
  logic        foreground_half_offset;
  logic [15:0] eq_w;
  logic [15:0] sp_w;
  logic [15:0] half_len;
  modport ctl (output csync_mode, sync_mode, prio, foreground_half_offset, eq_w, sp_w, half_len);
  modport use_cfg (input csync_mode, sync_mode, prio, foreground_half_offset, eq_w, sp_w, half_len);
endinterface

// ===== core/dmc_csync_gen.sv
`timescale 1ns/1ps
module dmc_csync_gen
  import dmc_pkg::*;
(
  input  wire logic pclk,         // Display clock
  input  wire logic presetn,      // Async reset, active low
  dmc_cfg_if.use_cfg cfg,         // Mode settings
  input  wire logic hs_n,         // Effective horizontal sync
  input  wire logic vs_n,         // Effective vertical sync
  output logic      csync_n,      // Composite sync, registered
  output logic      train_active  // Equalizing or separation in progress
);
  typedef enum logic [2:0] {ST_HSYNC, ST_DELAY, ST_EQ1, ST_SEP, ST_EQ2} dmc_cs_state_t;
  dmc_cs_state_t st_r;
  logic          vs_d_r;
  logic [15:0]   pos_r;
  logic [3:0]    cnt_r;
  logic          vfall;
  logic          half_end;
  logic [3:0]    halves;
  logic          cs_nxt;

  assign vfall    = vs_d_r & ~vs_n;
  assign half_end = (pos_r >= cfg.half_len - 16'h0001);
  assign halves   = (cfg.csync_mode == CS_HALF) ? HALVES_HALF : HALVES_THREE;

  // Half raster position, realigned at vertical sync fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vs_d_r <= 1'b1;
      pos_r  <= 16'h0000;
    end else begin
      vs_d_r <= vs_n;
      pos_r  <= (vfall || half_end) ? 16'h0000 : pos_r + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r  <= ST_HSYNC;
      cnt_r <= 4'h0;
    end else if (!cfg.csync_mode[1]) begin
      st_r  <= ST_HSYNC;
      cnt_r <= 4'h0;
    end else if (vfall) begin
      st_r  <= (cfg.csync_mode == CS_HALF) ? ST_DELAY : ST_EQ1;
      cnt_r <= 4'h0;
    end else if (half_end && st_r != ST_HSYNC) begin
      if (st_r == ST_DELAY || cnt_r == halves - 4'h1) begin
        cnt_r <= 4'h0;
        case (st_r)
          ST_DELAY: st_r <= ST_EQ1;
          ST_EQ1:   st_r <= ST_SEP;
          ST_SEP:   st_r <= ST_EQ2;
          default:  st_r <= ST_HSYNC;
        endcase
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  always_comb begin
    cs_nxt = hs_n;
    if (cfg.sync_mode != SM_MASTER) begin
      cs_nxt = 1'b1;
    end else if (cfg.csync_mode == CS_XOR) begin
      cs_nxt = ~(hs_n ^ vs_n);
    end else if (cfg.csync_mode[1]) begin
      case (st_r)
        ST_EQ1, ST_EQ2: cs_nxt = (pos_r >= cfg.eq_w);
        ST_SEP:         cs_nxt = (pos_r >= cfg.half_len - cfg.sp_w);
        default:        cs_nxt = hs_n;
      endcase
    end
  end

  // Registered composite sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csync_n      <= 1'b1;
      train_active <= 1'b0;
    end else begin
      csync_n      <= cs_nxt;
      train_active <= (st_r == ST_EQ1) || (st_r == ST_SEP) || (st_r == ST_EQ2);
    end
  end

  property p_xor_sync;
    @(posedge pclk) disable iff (!presetn)
      (cfg.sync_mode == SM_MASTER && cfg.csync_mode == CS_XOR) |=> csync_n == ~($past(hs_n) ^ $past(vs_n));
  endproperty
  a_xor_sync: assert property (p_xor_sync) else $error("xor composite sync wrong");

  sequence s_vfall_three;
    cfg.sync_mode == SM_MASTER && cfg.csync_mode == CS_THREE && vfall && cfg.eq_w != 16'h0000;
  endsequence
  property p_eq_start;
    @(posedge pclk) disable iff (!presetn)
      s_vfall_three |=> ##1 (!csync_n && train_active);
  endproperty
  a_eq_start: assert property (p_eq_start) else $error("equalizing train did not start");

  property p_tv_high;
    @(posedge pclk) disable iff (!presetn)
      (cfg.sync_mode == SM_TV) [*2] |=> csync_n;
  endproperty
  a_tv_high: assert property (p_tv_high) else $error("composite sync not high in tv mode");
endmodule

// ===== core/dmc_layer_sel.sv
`timescale 1ns/1ps
module dmc_layer_sel
  import dmc_pkg::*;
(
  input  wire logic       pclk,       // Display clock
  input  wire logic       presetn,    // Async reset, active low
  dmc_cfg_if.use_cfg      cfg,        // Mode settings
  input  wire logic [4:0] layer_hit,  // Opaque pixel per layer
  output logic [2:0]      top_layer,  // Visible layer, registered
  output logic [10:0]     fg_x_start  // Foreground screen 1 start x
);
  logic [14:0] order;
  logic [2:0]  pick;

  always_comb begin
    case (cfg.prio)
      2'h2:    order = PRIO_ORDER_10;
      2'h3:    order = PRIO_ORDER_11;
      default: order = PRIO_ORDER_00;
    endcase
    pick = LYR_NONE;
    for (int i = 4; i >= 0; i--) begin
      if (layer_hit[order[i*3 +: 3]]) begin
        pick = order[i*3 +: 3];
      end
    end
  end

  // Registered layer choice and start offset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_layer  <= LYR_NONE;
      fg_x_start <= FG_START_ZERO;
    end else begin
      top_layer  <= pick;
      fg_x_start <= cfg.foreground_half_offset ? FG_START_HALF : FG_START_ZERO;
    end
  end

  property p_cur1_top;
    @(posedge pclk) disable iff (!presetn)
      (cfg.prio == 2'h0 && layer_hit[LYR_CUR1]) |=> top_layer == LYR_CUR1;
  endproperty
  a_cur1_top: assert property (p_cur1_top) else $error("cursor 1 not on top");

  property p_fg_over_cur;
    @(posedge pclk) disable iff (!presetn)
      (cfg.prio == 2'h3 && layer_hit[LYR_FG]) |=> top_layer == LYR_FG;
  endproperty
  a_fg_over_cur: assert property (p_fg_over_cur) else $error("foreground not on top");

  property p_fg_offset;
    @(posedge pclk) disable iff (!presetn)
      cfg.foreground_half_offset |=> fg_x_start == FG_START_HALF;
  endproperty
  a_fg_offset: assert property (p_fg_offset) else $error("foreground offset wrong");
endmodule

// ===== core/dmc_mode_ctrl.sv
// Summary of operation
// - Reset clears mode bits except composite sync
// - Bit 12 set disables video switch pin
// - Video switch pin picks external or own video
// - Bit 10 selects RGB or YC window data
// - Bit 9 starts foreground 1 at x 512
// - Bit 8 selects field signal polarity
// - Code 00 gives vsync xor hsync; 01 prohibited
// - Code 10: three-raster equalize, separate, equalize
// - Code 11: half-raster delay, 2.5-raster trains
// - Priority field is bit 11 over bit 5
// - Priority 00: cursors, foreground, video, background
// - Sync mode 10 inputs signals, composite held high
`timescale 1ns/1ps
module dmc_mode_ctrl
  import dmc_pkg::*;
#(
  parameter logic [15:0] HALF_DEFAULT = HALF_RESET
) (
  input  wire logic        pclk,                        // Display clock, 100 MHz
  input  wire logic        presetn,                     // Async reset, active low
  input  wire logic [7:0]  paddr,                       // APB byte address
  input  wire logic        psel,                        // APB select
  input  wire logic        penable,                     // APB access phase
  input  wire logic        pwrite,                      // APB write
  input  wire logic [31:0] pwdata,                      // APB write data
  output logic      [31:0] prdata,                      // APB read data
  output logic             pready,                      // APB ready
  output logic             pslverr,                     // APB error on unmapped address
  input  wire logic        int_hsync_n,                 // Master raster hsync
  input  wire logic        int_vsync_n,                 // Master raster vsync
  input  wire logic        int_first_field,             // Master raster first field
  input  wire logic        hsync_pin_i,                 // Hsync pin level
  output logic             hsync_pin_o,                 // Hsync pin drive
  output logic             hsync_pin_oe,                // Hsync pin enable
  input  wire logic        vsync_pin_i,                 // Vsync pin level
  output logic             vsync_pin_o,                 // Vsync pin drive
  output logic             vsync_pin_oe,                // Vsync pin enable
  input  wire logic        odd_even_field_signal_i,     // Field pin level
  output logic             odd_even_field_signal_o,     // Field pin drive
  output logic             odd_even_field_signal_oe,    // Field pin enable
  output logic             csync_n,                     // Composite sync, active low
  input  wire logic        display_active,              // Own colour output shown
  output logic             video_switch_pin_o,          // Video switch drive
  output logic             video_switch_pin_oe,         // Video switch enable
  input  wire logic [4:0]  layer_hit,                   // Opaque pixel per layer
  output logic      [2:0]  top_layer,                   // Visible layer
  output logic      [10:0] fg_x_start,                  // Foreground 1 start x
  output logic             video_window_format_select   // 1 means YC source data
);
  dmc_cfg_if cfg ();

  logic [15:0] mode_r;
  logic [1:0]  csy_r;
  logic [15:0] eqw_r;
  logic [15:0] spw_r;
  logic [15:0] half_r;
  logic [1:0]  sync_r;
  logic [2:0]  pin_in;
  logic [2:0]  s1_r;
  logic [2:0]  s2_r;
  logic [2:0]  s3_r;
  logic [2:0]  filt_r;
  logic        hs_eff;
  logic        vs_eff;
  logic        train_active;
  logic        setup;
  logic        wr_go;
  logic        mapped;
  logic [31:0] rd_nxt;
  logic [15:0] mode_view;
  logic        master;

  assign setup     = psel & ~penable;
  assign wr_go     = psel & penable & pready & pwrite & ~pslverr;
  assign master    = (sync_r == SM_MASTER);
  assign mode_view = (mode_r & ~MODE_CSY_MASK) | {8'h00, csy_r, 6'h00};

  // Address decode of mapped registers
  always_comb begin
    case (paddr)
      OFS_MODE, OFS_EQW, OFS_SPW, OFS_SYNC, OFS_HALF, OFS_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_RESET;
    end else if (wr_go && paddr == OFS_MODE) begin
      mode_r <= pwdata[15:0] & MODE_WMASK & ~MODE_CSY_MASK;
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_go && paddr == OFS_MODE) begin
      csy_r <= pwdata[BIT_CSY_HI:BIT_CSY_LO];
    end
  end

  // Pulse widths, half raster length and sync source mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eqw_r  <= 16'h0000;
      spw_r  <= 16'h0000;
      half_r <= HALF_DEFAULT;
      sync_r <= SYNC_RESET;
    end else if (wr_go) begin
      case (paddr)
        OFS_EQW:  eqw_r  <= pwdata[15:0];
        OFS_SPW:  spw_r  <= pwdata[15:0];
        OFS_HALF: half_r <= pwdata[15:0];
        OFS_SYNC: sync_r <= pwdata[1:0];
        default:  ;
      endcase
    end
  end

  // Read mux, sampled in the setup cycle
  always_comb begin
    case (paddr)
      OFS_MODE: rd_nxt = {16'h0000, mode_view};
      OFS_EQW:  rd_nxt = {16'h0000, eqw_r};
      OFS_SPW:  rd_nxt = {16'h0000, spw_r};
      OFS_HALF: rd_nxt = {16'h0000, half_r};
      OFS_SYNC: rd_nxt = {30'h00000000, sync_r};
      OFS_STAT: rd_nxt = {27'h0000000, train_active, csync_n, filt_r};
      default:  rd_nxt = 32'h00000000;
    endcase
  end

  // APB answer one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_nxt;
      end
    end
  end

  // Configuration toward the sub-blocks
  // priority field assembly
  assign cfg.prio       = {mode_r[BIT_PRI_HI], mode_r[BIT_PRI_LO]};
  assign cfg.csync_mode = csy_r;
  assign cfg.sync_mode  = sync_r;
  assign cfg.foreground_half_offset       = mode_r[BIT_FOREGROUND_HALF_OFFSET];
  assign cfg.eq_w       = eqw_r;
  assign cfg.sp_w       = spw_r;
  assign cfg.half_len   = half_r;

  // Three stage pin synchronisers, change taken when stages two and three agree
  assign pin_in = {odd_even_field_signal_i, vsync_pin_i, hsync_pin_i};
  generate
    for (genvar g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[g]   <= 1'b1;
          s2_r[g]   <= 1'b1;
          s3_r[g]   <= 1'b1;
          filt_r[g] <= 1'b1;
        end else begin
          s1_r[g] <= pin_in[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g]) begin
            filt_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate

  assign hs_eff = master ? int_hsync_n : filt_r[0];
  assign vs_eff = master ? int_vsync_n : filt_r[1];

  // pins driven only in master mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hsync_pin_o              <= 1'b1;
      hsync_pin_oe             <= 1'b0;
      vsync_pin_o              <= 1'b1;
      vsync_pin_oe             <= 1'b0;
      odd_even_field_signal_o  <= 1'b0;
      odd_even_field_signal_oe <= 1'b0;
    end else begin
      hsync_pin_o              <= int_hsync_n;
      hsync_pin_oe             <= master;
      vsync_pin_o              <= int_vsync_n;
      vsync_pin_oe             <= master;
      odd_even_field_signal_o  <= ~(int_first_field ^ mode_r[BIT_FIELD_POLARITY_SELECT]);
      odd_even_field_signal_oe <= master;
    end
  end

  // Video switch pin and window format
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      video_switch_pin_o         <= 1'b0;
      video_switch_pin_oe        <= 1'b0;
      video_window_format_select <= 1'b0;
    end else begin
      video_switch_pin_o         <= display_active;
      video_switch_pin_oe        <= ~mode_r[BIT_VIDEO_SWITCH_PIN_DISABLE];
      video_window_format_select <= mode_r[BIT_VIDEO_WINDOW_FORMAT_SELECT];
    end
  end

  dmc_csync_gen u_csync (
    .pclk         (pclk),
    .presetn      (presetn),
    .cfg          (cfg.use_cfg),
    .hs_n         (hs_eff),
    .vs_n         (vs_eff),
    .csync_n      (csync_n),
    .train_active (train_active)
  );

  dmc_layer_sel u_layer (
    .pclk       (pclk),
    .presetn    (presetn),
    .cfg        (cfg.use_cfg),
    .layer_hit  (layer_hit),
    .top_layer  (top_layer),
    .fg_x_start (fg_x_start)
  );

  property p_reset_clear;
    @(posedge pclk) $rose(presetn) |-> (mode_view & ~MODE_CSY_MASK) == 16'h0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("mode bits not cleared by reset");

  property p_pin_disable;
    @(posedge pclk) disable iff (!presetn)
      mode_r[BIT_VIDEO_SWITCH_PIN_DISABLE] |=> !video_switch_pin_oe;
  endproperty
  a_pin_disable: assert property (p_pin_disable) else $error("video switch pin still driven");

  property p_format;
    @(posedge pclk) disable iff (!presetn)
      $changed(mode_r[BIT_VIDEO_WINDOW_FORMAT_SELECT]) |=> video_window_format_select == $past(mode_r[BIT_VIDEO_WINDOW_FORMAT_SELECT]);
  endproperty
  a_format: assert property (p_format) else $error("window format select lags");

  property p_field_pol;
    @(posedge pclk) disable iff (!presetn)
      (master && int_first_field && !mode_r[BIT_FIELD_POLARITY_SELECT]) |=> !odd_even_field_signal_o;
  endproperty
  a_field_pol: assert property (p_field_pol) else $error("field signal not low in first field");

  property p_tv_inputs;
    @(posedge pclk) disable iff (!presetn)
      (sync_r == SM_TV) |=> !hsync_pin_oe && !vsync_pin_oe && !odd_even_field_signal_oe;
  endproperty
  a_tv_inputs: assert property (p_tv_inputs) else $error("sync pins driven in tv mode");

  sequence s_apb_setup;
    psel && !penable;
  endsequence
  property p_apb_ready;
    @(posedge pclk) disable iff (!presetn)
      s_apb_setup |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb ready not one cycle");

  property p_keep_csy;
    @(posedge pclk) disable iff (!presetn)
      !(wr_go && paddr == OFS_MODE) |=> csy_r === $past(csy_r);
  endproperty
  a_keep_csy: assert property (p_keep_csy) else $error("composite sync bits changed");
endmodule

// ===== verif/dmc_sync_partner.sv
`timescale 1ns/1ps
// External sync circuit on the far side of the two-way sync pins
module dmc_sync_partner (
  input  wire logic [2:0] drv_o,    // Device pin drive values
  input  wire logic [2:0] drv_oe,   // Device pin enables
  input  wire logic [2:0] ext_lvl,  // Levels the external circuit drives
  output logic      [2:0] pin_lvl   // Resolved pin levels
);
  logic [2:0] own_oe;
  assign own_oe = ~drv_oe;
  // Wire level from both parties
  assign pin_lvl = (drv_oe & drv_o) | (own_oe & ext_lvl);
endmodule

// ===== verif/dmc_mode_ctrl_tb_top.sv
`timescale 1ns/1ps
module dmc_mode_ctrl_tb_top;
  import dmc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        hs_n, vs_n, first, dact, csync_n, fmt, sw_o, sw_oe;
  logic [2:0]  pin_o, pin_oe, pin_i, ext_lvl, top_layer;
  logic [4:0]  hit;
  logic [10:0] fgx;
  logic [15:0] v;
  logic [32:0] e;
  logic [36:0] exp_q[$];
  int          mismatches, n_checks, seed;
  int          ord[3][5] = '{'{0, 1, 2, 3, 4}, '{0, 2, 3, 1, 4}, '{2, 3, 0, 1, 4}};

  dmc_mode_ctrl #(.HALF_DEFAULT(16'h0010)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .int_hsync_n(hs_n), .int_vsync_n(vs_n), .int_first_field(first),
    .hsync_pin_i(pin_i[0]), .hsync_pin_o(pin_o[0]), .hsync_pin_oe(pin_oe[0]),
    .vsync_pin_i(pin_i[1]), .vsync_pin_o(pin_o[1]), .vsync_pin_oe(pin_oe[1]),
    .odd_even_field_signal_i(pin_i[2]), .odd_even_field_signal_o(pin_o[2]),
    .odd_even_field_signal_oe(pin_oe[2]), .csync_n(csync_n), .display_active(dact),
    .video_switch_pin_o(sw_o), .video_switch_pin_oe(sw_oe), .layer_hit(hit),
    .top_layer(top_layer), .fg_x_start(fgx), .video_window_format_select(fmt));

  dmc_sync_partner far (.drv_o(pin_o), .drv_oe(pin_oe), .ext_lvl(ext_lvl), .pin_lvl(pin_i));

  // Clock, 10 ns period
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One APB transfer; a read notes its expected response first
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] x);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) exp_q.push_back({4'h0, x});
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic note(input logic [3:0] s, input logic [32:0] x);
    exp_q.push_back({s, x});
  endtask

  function automatic logic [32:0] pick(input logic [3:0] s);
    case (s)
      4'h1: pick = {30'h0, top_layer};
      4'h2: pick = {22'h0, fgx};
      4'h3: pick = {28'h0, sw_oe, pin_oe, fmt};
      default: pick = {30'h0, sw_o, csync_n, pin_o[2]};
    endcase
  endfunction

  // Compare the oldest note with the outputs when a result shows
  always @(pclk) begin : mon
    logic [36:0] q;
    if (pclk && psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      q = exp_q.pop_front();
      check({pslverr, prdata}, q[32:0]);
    end
    while (!pclk && exp_q.size() > 0 && exp_q[0][36:33] != 4'h0) begin
      q = exp_q.pop_front();
      check(pick(q[36:33]), q[32:0]);
    end
  end

  // Main sequence
  initial begin
    seed = 71;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {hs_n, vs_n, first, dact, hit, ext_lvl} = 12'hC00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(OFS_MODE, 1'b1, 32'h0, 33'h0);
    apb(OFS_SYNC, 1'b0, 32'h0, {31'h0, SYNC_RESET});
    apb(8'h18, 1'b0, 32'h0, {1'b1, 32'h0});
    for (int i = 0; i < 6; i++) begin
      v = 16'($random(seed));
      v[6] = v[6] & v[7];
      v[5] = v[5] & v[11];
      // mode changes only while the display is idle
      apb(OFS_MODE, 1'b1, {16'h0, v}, 33'h0);
      apb(OFS_MODE, 1'b0, 32'h0, {17'h0, v & MODE_WMASK});
      @(posedge pclk);
      note(4'h2, v[9] ? 33'h200 : 33'h0);
      note(4'h3, {28'h0, ~v[12], 3'b000, v[10]});
      @(negedge pclk);
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      apb(OFS_MODE, 1'b0, 32'h0, {17'h0, v & MODE_CSY_MASK});
    end
    for (int p = 0; p < 3; p++) begin
      apb(OFS_MODE, 1'b1, {20'h0, p > 0, 5'h0, p == 2, 5'h0}, 33'h0);
      for (int k = 0; k < 8; k++) begin
        @(posedge pclk);
        hit <= 5'($random(seed));
        @(posedge pclk);
        e = 33'(LYR_NONE);
        for (int j = 4; j >= 0; j--) if (hit[ord[p][j]]) e = 33'(ord[p][j]);
        note(4'h1, e);
        @(negedge pclk);
      end
    end
    v = 16'($random(seed)) & 16'h0100;
    apb(OFS_SYNC, 1'b1, 32'(SM_MASTER), 33'h0);
    apb(OFS_MODE, 1'b1, {16'h0, v}, 33'h0);
    for (int k = 0; k < 12; k++) begin
      @(posedge pclk);
      {hs_n, vs_n, first, dact} <= 4'($random(seed));
      repeat (2) @(posedge pclk);
      note(4'h4, {30'h0, dact, ~(hs_n ^ vs_n), ~(first ^ v[8])});
      note(4'h3, 33'h1E);
      @(negedge pclk);
    end
    // Code 10 train: equalizing low two edges after vsync falls
    apb(OFS_EQW, 1'b1, 32'h2, 33'h0);
    apb(OFS_SPW, 1'b1, 32'h2, 33'h0);
    apb(OFS_MODE, 1'b1, {16'h0, v | 16'h0080}, 33'h0);
    @(posedge pclk);
    vs_n <= 1'b1;
    repeat (3) @(posedge pclk);
    vs_n <= 1'b0;
    repeat (2) @(posedge pclk);
    note(4'h4, {30'h0, dact, 1'b0, ~(first ^ v[8])});
    @(negedge pclk);
    apb(OFS_MODE, 1'b1, 32'h0, 33'h0);
    apb(OFS_SYNC, 1'b1, 32'(SM_TV), 33'h0);
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      ext_lvl <= 3'($random(seed));
      repeat (8) @(posedge pclk);
      apb(OFS_STAT, 1'b0, 32'h0, {28'h1, ext_lvl});
    end
    repeat (4) @(posedge pclk);
    give_verdict();
  end

  // Watchdog against a hung handshake
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule
